// *** rtl/acls_regs.sv ***
`timescale 1ns/1ps

module acls_regs
    import acls_pkg::*;
#(
    parameter int TYPE_W = 4,
    parameter int CSUM_W = 8,
    parameter int NCTS_W = 20
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // serial control bus register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // bridge audio source select
    input wire logic [1:0] audio_src_sel_i,
    // hdmi packet fields and update strobes
    input wire logic aud_type_vld_i,
    input wire logic [TYPE_W-1:0] aud_type_i,
    input wire logic aif_vld_i,
    input wire logic [CSUM_W-1:0] aif_csum_i,
    input wire logic avi_vld_i,
    input wire logic [CSUM_W-1:0] avi_csum_i,
    input wire logic acr_vld_i,
    input wire logic [NCTS_W-1:0] acr_n_i,
    input wire logic [NCTS_W-1:0] acr_cts_i,
    // audio sources
    input wire acls_i2s_s hdmi_i2s_i,
    input wire acls_i2s_s pin_i2s_i,
    input wire acls_i2s_s tdm_par_i,
    // i2s pins (two-way)
    output acls_i2s_s pin_i2s_o,
    output logic pin_i2s_oe_o,
    // audio controls and downstream audio
    output logic tdm_conv_en_o,
    output acls_i2s_s link_audio_o,
    output logic fifo_reset_o,
    // link and receiver status sources
    input wire acls_link_s link_i
);

    // ==================================================
    // register file
    logic [7:0] aud_conf_r;
    logic [7:0] aud_conf_nxt;
    logic [7:0] link_sts_r;
    logic [7:0] link_sts_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // address decode
    wire sel_cfg = (reg_addr_i == ACLS_AUD_CONF_OFS);
    wire sel_sts = (reg_addr_i == ACLS_LINK_STS_OFS);
    wire wr_cfg = reg_wr_i && sel_cfg;

    // reserved bits 5:4 stay zero, status is not writable
    assign aud_conf_nxt = wr_cfg ? (reg_wdata_i & ACLS_AUD_CONF_WMASK)
                                 : aud_conf_r;

    // read mux, unmapped reads as zero
    assign rdata_nxt = sel_cfg ? aud_conf_r :
                       sel_sts ? link_sts_r : ACLS_UNMAPPED_RDATA;

    // ==================================================
    // configuration fields
    wire tdm_en = aud_conf_r[ACLS_TDM_CONV_EN_BIT];
    wire hdmi_out_req = aud_conf_r[ACLS_HDMI_I2S_OUT_BIT];
    wire rst_on_type = aud_conf_r[ACLS_RST_ON_TYPE_BIT];
    wire aif_rst_en = aud_conf_r[ACLS_AIF_RST_EN_BIT];
    wire avi_rst_en = aud_conf_r[ACLS_AVI_RST_EN_BIT];
    wire acr_rst_en = aud_conf_r[ACLS_ACR_RST_EN_BIT];
    wire src_hdmi = (audio_src_sel_i == ACLS_SRC_HDMI);

    // ==================================================
    // status composition
    wire tx_ok = link_i.tx_active && link_i.rx_locked
                 && link_i.video_valid && link_i.mode_entered;
    wire [1:0] port_mode = tx_ok ? link_i.port_mode
                                 : ACLS_PORT_DUAL;

    always_comb begin
        link_sts_nxt = ACLS_LINK_STS_RST;
        link_sts_nxt[ACLS_LINK_RDY_BIT] = link_i.link_ready;
        link_sts_nxt[ACLS_TX_ACTIVE_BIT] = tx_ok;
        link_sts_nxt[ACLS_PORT_MODE_HI:ACLS_PORT_MODE_LO] = port_mode;
        link_sts_nxt[ACLS_TMDS_OK_BIT] = link_i.tmds_ok;
        link_sts_nxt[ACLS_PLL_LOCK_BIT] = link_i.pll_lock;
        link_sts_nxt[ACLS_NO_CLK_BIT] = link_i.no_clk;
        link_sts_nxt[ACLS_FREQ_STEADY_BIT] = link_i.freq_steady;
    end

    // ==================================================
    // register and read data flops
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aud_conf_r <= ACLS_AUD_CONF_RST;
            link_sts_r <= ACLS_LINK_STS_RST;
            rdata_r <= ACLS_UNMAPPED_RDATA;
        end else begin
            aud_conf_r <= aud_conf_nxt;
            link_sts_r <= link_sts_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;

    // ==================================================
    // fifo reset triggers
    logic type_chg;
    logic aif_chg;
    logic avi_chg;
    logic acr_chg;

    acls_change_det #(.W(TYPE_W)) u_type_det (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .valid_i(aud_type_vld_i),
        .value_i(aud_type_i),
        .change_o(type_chg)
    );

    acls_change_det #(.W(CSUM_W)) u_aif_det (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .valid_i(aif_vld_i),
        .value_i(aif_csum_i),
        .change_o(aif_chg)
    );

    acls_change_det #(.W(CSUM_W)) u_avi_det (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .valid_i(avi_vld_i),
        .value_i(avi_csum_i),
        .change_o(avi_chg)
    );

    acls_change_det #(.W(2*NCTS_W)) u_acr_det (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .valid_i(acr_vld_i),
        .value_i({acr_n_i, acr_cts_i}),
        .change_o(acr_chg)
    );

    // gated triggers combined into one request
    wire fifo_rst_req = (rst_on_type && type_chg)
                        || (aif_rst_en && aif_chg)
                        || (avi_rst_en && avi_chg)
                        || (acr_rst_en && acr_chg);

    logic fifo_rst_r;

    // registered reset pulse one cycle after any enabled detected change, simultaneous changes giving one pulse
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fifo_rst_r <= 1'b0;
        end else begin
            fifo_rst_r <= fifo_rst_req;
        end
    end

    assign fifo_reset_o = fifo_rst_r;

    // ==================================================
    // audio routing
    wire pin_drive = hdmi_out_req && src_hdmi;
    wire acls_i2s_s src_audio = src_hdmi ? hdmi_i2s_i : pin_i2s_i;
    wire acls_i2s_s link_audio_nxt = tdm_en ? tdm_par_i : src_audio;

    acls_i2s_s pin_i2s_r;
    acls_i2s_s link_audio_r;
    logic pin_oe_r;

    // registered pin and downstream audio
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_i2s_r <= '0;
            pin_oe_r <= 1'b0;
            link_audio_r <= '0;
        end else begin
            pin_i2s_r <= pin_drive ? hdmi_i2s_i : '0;
            pin_oe_r <= pin_drive;
            link_audio_r <= link_audio_nxt;
        end
    end

    assign pin_i2s_o = pin_i2s_r;
    assign pin_i2s_oe_o = pin_oe_r;
    assign link_audio_o = link_audio_r;
    assign tdm_conv_en_o = tdm_en;

    // ==================================================
    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    tdm_enable_a: assert property (
        wr_cfg |=> tdm_conv_en_o == $past(reg_wdata_i[ACLS_TDM_CONV_EN_BIT]))
        else $error("converter enable mismatch");

    tdm_clock_a: assert property (
        tdm_en |=> link_audio_o == $past(tdm_par_i))
        else $error("downstream not from converter");

    pin_drive_a: assert property (
        (hdmi_out_req && src_hdmi)
        |=> pin_i2s_oe_o && pin_i2s_o == $past(hdmi_i2s_i))
        else $error("hdmi audio not on pins");

    pin_ignore_a: assert property (
        !src_hdmi |=> !pin_i2s_oe_o)
        else $error("pins driven with non-hdmi source");

    type_reset_a: assert property (
        (rst_on_type && type_chg) |=> fifo_reset_o)
        else $error("no fifo reset on type change");

    aif_reset_a: assert property (
        (aif_rst_en && aif_chg) |=> fifo_reset_o)
        else $error("no fifo reset on infoframe change");

    avi_reset_a: assert property (
        (avi_rst_en && avi_chg) |=> fifo_reset_o)
        else $error("no fifo reset on video infoframe change");

    acr_reset_a: assert property (
        (acr_rst_en && acr_chg) |=> fifo_reset_o)
        else $error("no fifo reset on clock regen change");

    link_ready_a: assert property (
        ##1 link_sts_r[ACLS_LINK_RDY_BIT] == $past(link_i.link_ready))
        else $error("link ready status wrong");

    tx_status_a: assert property (
        link_sts_r[ACLS_TX_ACTIVE_BIT] |-> $past(link_i.tx_active)
        && $past(link_i.rx_locked))
        else $error("tx status without lock");

    tx_qualify_a: assert property (
        link_sts_r[ACLS_TX_ACTIVE_BIT] |-> $past(link_i.video_valid)
        && $past(link_i.mode_entered))
        else $error("tx status before video or mode");

    port_mode_a: assert property (
        link_sts_r[ACLS_TX_ACTIVE_BIT]
        |-> link_sts_r[ACLS_PORT_MODE_HI:ACLS_PORT_MODE_LO]
            == $past(link_i.port_mode))
        else $error("port mode field wrong");

    rx_flags_a: assert property (
        ##1 link_sts_r[ACLS_TMDS_OK_BIT] == $past(link_i.tmds_ok))
        else $error("tmds flag wrong");

    pll_flag_a: assert property (
        ##1 link_sts_r[ACLS_PLL_LOCK_BIT] == $past(link_i.pll_lock))
        else $error("pll lock flag wrong");

    no_clock_a: assert property (
        ##1 link_sts_r[ACLS_NO_CLK_BIT] == $past(link_i.no_clk))
        else $error("no clock flag wrong");

    freq_flag_a: assert property (
        ##1 link_sts_r[ACLS_FREQ_STEADY_BIT] == $past(link_i.freq_steady))
        else $error("frequency flag wrong");

    local_src_a: assert property (
        (!src_hdmi && !tdm_en) |=> link_audio_o == $past(pin_i2s_i))
        else $error("local audio not sent");

    reset_pulse_a: assert property (
        fifo_reset_o |-> $past(fifo_rst_req))
        else $error("fifo reset without trigger");

    reserved_a: assert property (
        aud_conf_r[5:4] == 2'h0)
        else $error("reserved bits set");

endmodule

// *** pkg/acls_pkg.sv ***
package acls_pkg;

    // ==================================================
    // register map
    localparam logic [7:0] ACLS_AUD_CONF_OFS = 8'h55;
    localparam logic [7:0] ACLS_LINK_STS_OFS = 8'h5a;
    localparam logic [7:0] ACLS_AUD_CONF_RST = 8'h0c;
    localparam logic [7:0] ACLS_LINK_STS_RST = 8'h00;
    localparam logic [7:0] ACLS_AUD_CONF_WMASK = 8'hcf;
    localparam logic [7:0] ACLS_UNMAPPED_RDATA = 8'h00;

    // ==================================================
    // audio configuration field positions
    localparam int ACLS_TDM_CONV_EN_BIT = 7;
    localparam int ACLS_HDMI_I2S_OUT_BIT = 6;
    localparam int ACLS_RST_ON_TYPE_BIT = 3;
    localparam int ACLS_AIF_RST_EN_BIT = 2;
    localparam int ACLS_AVI_RST_EN_BIT = 1;
    localparam int ACLS_ACR_RST_EN_BIT = 0;

    // ==================================================
    // link status field positions
    localparam int ACLS_LINK_RDY_BIT = 7;
    localparam int ACLS_TX_ACTIVE_BIT = 6;
    localparam int ACLS_PORT_MODE_HI = 5;
    localparam int ACLS_PORT_MODE_LO = 4;
    localparam int ACLS_TMDS_OK_BIT = 3;
    localparam int ACLS_PLL_LOCK_BIT = 2;
    localparam int ACLS_NO_CLK_BIT = 1;
    localparam int ACLS_FREQ_STEADY_BIT = 0;

    // ==================================================
    // port mode codes and audio source selection
    localparam logic [1:0] ACLS_PORT_DUAL = 2'h0;
    localparam logic [1:0] ACLS_PORT_SINGLE0 = 2'h1;
    localparam logic [1:0] ACLS_PORT_SINGLE1 = 2'h2;
    localparam logic [1:0] ACLS_PORT_REPLICATE = 2'h3;
    localparam logic [1:0] ACLS_SRC_HDMI = 2'h0;

    // ==================================================
    // carriers
    typedef struct packed {
        logic sck;
        logic ws;
        logic [3:0] sd;
    } acls_i2s_s;

    typedef struct packed {
        logic link_ready;
        logic tx_active;
        logic rx_locked;
        logic video_valid;
        logic mode_entered;
        logic [1:0] port_mode;
        logic tmds_ok;
        logic pll_lock;
        logic no_clk;
        logic freq_steady;
    } acls_link_s;

endpackage

// *** rtl/acls_change_det.sv ***
`timescale 1ns/1ps

module acls_change_det
    import acls_pkg::*;
#(
    parameter int W = 8
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // sampled field
    input wire logic valid_i,
    input wire logic [W-1:0] value_i,
    // change event
    output logic change_o
);

    logic [W-1:0] last_r;
    logic seen_r;
    logic change_r;
    wire differs = seen_r && (value_i != last_r);

    // ==================================================
    // remember last field, flag a change once per update
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_r <= '0;
            seen_r <= 1'b0;
            change_r <= 1'b0;
        end else begin
            change_r <= valid_i && differs;
            if (valid_i) begin
                last_r <= value_i;
                seen_r <= 1'b1;
            end
        end
    end

    assign change_o = change_r;

    // ==================================================
    // checks
    property p_change;
        @(posedge mclk_i) disable iff (!rst_n_i)
        (valid_i && differs) |=> change_o;
    endproperty
    change_on_diff_a: assert property (p_change)
        else $error("change not flagged");

    one_shot_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        change_o |-> $past(valid_i))
        else $error("change without update");

endmodule

// *** testbench/acls_host_model.sv ***
`timescale 1ns/1ps

// ==================================================
// host side of the register port
module acls_host_model (
    // clock
    input wire logic mclk_i,
    // register port
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    // idle bus at time zero
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // one write, strobe up for a single edge
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge mclk_i);
        reg_wr_o <= 1'b0;
    endtask

    // address held, registered data taken after the answer edge
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_o <= a;
        @(posedge mclk_i);
        @(posedge mclk_i);
        #1;
        d = reg_rdata_i;
    endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps

// ==================================================
// compare helper
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
    n_fail++; $display("MISMATCH %s exp=%h got=%h", nm, exp, got); end end

module tb_top;
    import acls_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic reg_wr_i;
    logic [1:0] audio_src_sel_i = 2'h0;
    logic [3:0] vld = 4'h0;
    logic [3:0] aud_type_i = 4'h0;
    logic [7:0] aif_csum_i = 8'h00;
    logic [7:0] avi_csum_i = 8'h00;
    logic [19:0] acr_n_i = 20'h0;
    logic [19:0] acr_cts_i = 20'h0;
    acls_i2s_s hdmi_i2s_i = 6'h15;
    acls_i2s_s pin_i2s_i = 6'h2a;
    acls_i2s_s tdm_par_i = 6'h33;
    acls_i2s_s pin_i2s_o, link_audio_o;
    logic pin_i2s_oe_o, tdm_conv_en_o, fifo_reset_o;
    acls_link_s link_i = '0;
    logic [5:0] seen;
    int n_fail = 0;
    int comparisons = 0;

    // ==================================================
    // clock, partner and device
    always #4 mclk_i = ~mclk_i;

    acls_host_model u_acls_host_model (.mclk_i(mclk_i),
        .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
        .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o));

    acls_regs u_acls_regs (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .audio_src_sel_i(audio_src_sel_i),
        .aud_type_vld_i(vld[3]), .aud_type_i(aud_type_i),
        .aif_vld_i(vld[2]), .aif_csum_i(aif_csum_i),
        .avi_vld_i(vld[1]), .avi_csum_i(avi_csum_i),
        .acr_vld_i(vld[0]), .acr_n_i(acr_n_i), .acr_cts_i(acr_cts_i),
        .hdmi_i2s_i(hdmi_i2s_i), .pin_i2s_i(pin_i2s_i),
        .tdm_par_i(tdm_par_i), .pin_i2s_o(pin_i2s_o),
        .pin_i2s_oe_o(pin_i2s_oe_o), .tdm_conv_en_o(tdm_conv_en_o),
        .link_audio_o(link_audio_o), .fifo_reset_o(fifo_reset_o),
        .link_i(link_i));

    // ==================================================
    // tasks
    task automatic end_sim;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_acls_host_model.read_reg(a, d);
        `CHK("rdata", exp, d)
    endtask

    // status from a link vector, after load and read latency
    task automatic chk_sts(input acls_link_s l, input logic [7:0] exp);
        @(posedge mclk_i);
        link_i <= l;
        repeat (2) @(posedge mclk_i);
        chk_reg(ACLS_LINK_STS_OFS, exp);
    endtask

    // update strobes, then record where fifo reset pulses fall
    task automatic fire(input logic [3:0] which, input logic [19:0] v,
                        input logic [5:0] exp);
        @(posedge mclk_i);
        vld <= which;
        aud_type_i <= v[3:0];
        aif_csum_i <= v[7:0];
        avi_csum_i <= v[7:0];
        acr_n_i <= v;
        acr_cts_i <= ~v;
        @(posedge mclk_i);
        vld <= 4'h0;
        seen = 6'h00;
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk_i);
            #1;
            seen[i] = (fifo_reset_o === 1'b1);
        end
        `CHK("fifo_reset", exp, seen)
    endtask

    // audio routing after source select settles
    task automatic set_src(input logic [1:0] s);
        @(posedge mclk_i);
        audio_src_sel_i <= s;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    // ==================================================
    // watchdog
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end

    // ==================================================
    // main sequence
    initial begin
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        chk_reg(ACLS_AUD_CONF_OFS, 8'h0c);
        chk_reg(ACLS_LINK_STS_OFS, 8'h00);
        chk_reg(8'h33, 8'h00);
        u_acls_host_model.write_reg(ACLS_LINK_STS_OFS, 8'hff);
        chk_reg(ACLS_LINK_STS_OFS, 8'h00);
        chk_reg(ACLS_AUD_CONF_OFS, 8'h0c);
        u_acls_host_model.write_reg(ACLS_AUD_CONF_OFS, 8'hff);
        chk_reg(ACLS_AUD_CONF_OFS, 8'hcf);
        // converter on: its output goes downstream
        u_acls_host_model.write_reg(ACLS_AUD_CONF_OFS, 8'h80);
        set_src(2'h0);
        `CHK("tdm_en", 1'b1, tdm_conv_en_o)
        `CHK("link_audio", tdm_par_i, link_audio_o)
        // pin mirroring only with hdmi source
        u_acls_host_model.write_reg(ACLS_AUD_CONF_OFS, 8'h40);
        set_src(2'h0);
        `CHK("tdm_en", 1'b0, tdm_conv_en_o)
        `CHK("link_audio", hdmi_i2s_i, link_audio_o)
        `CHK("pin_oe", 1'b1, pin_i2s_oe_o)
        `CHK("pin_out", hdmi_i2s_i, pin_i2s_o)
        for (int s = 1; s < 4; s++) begin
            set_src(s[1:0]);
            `CHK("link_audio", pin_i2s_i, link_audio_o)
            `CHK("pin_oe", 1'b0, pin_i2s_oe_o)
        end
        // status fields
        chk_sts(11'h400, 8'h80);
        for (int i = 0; i < 4; i++) begin
            chk_sts(11'(1 << i), 8'(1 << i));
        end
        for (int p = 0; p < 4; p++) begin
            chk_sts(11'h3c0 | 11'(p << 4), 8'h40 | 8'(p << 4));
        end
        chk_sts(11'h370, 8'h00);
        chk_sts(11'h2f0, 8'h00);
        chk_sts(11'h330, 8'h00);
        // fifo reset triggers
        u_acls_host_model.write_reg(ACLS_AUD_CONF_OFS, 8'h0f);
        fire(4'hf, 20'h1, 6'h00);
        for (int k = 0; k < 4; k++) begin
            fire(4'(1 << k), 20'(k + 2), 6'h01);
        end
        fire(4'hf, 20'h9, 6'h01);
        fire(4'hf, 20'h9, 6'h00);
        u_acls_host_model.write_reg(ACLS_AUD_CONF_OFS, 8'h00);
        fire(4'hf, 20'ha, 6'h00);
        u_acls_host_model.write_reg(ACLS_AUD_CONF_OFS, 8'h01);
        fire(4'h8, 20'hb, 6'h00);
        fire(4'h1, 20'hc, 6'h01);
        // reset in mid-run: defaults back, first update only stores
        set_src(2'h0);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        chk_reg(ACLS_AUD_CONF_OFS, 8'h0c);
        fire(4'h4, 20'hd, 6'h00);
        fire(4'h4, 20'he, 6'h01);
        end_sim();
    end
endmodule
